// *** qbt_query_table.sv ***
// burst and page query table behind an ahb-lite slave port
// assumes a single ahb-lite master on the same clock, word transfers only
`default_nettype none

module qbt_query_table
    import qbt_pkg::*;
#(
    parameter logic [7:0] PART_REGIONS = QBT_PART_COUNT_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    qbt_state_type st;
    qbt_state_type next_st;
    logic          accept;
    logic          acc_rd;
    logic [9:0]    idx;

    // only word transfers are issued, so size carries no decode
    assign accept = hsel && hready && (htrans == QBT_HTRANS_NONSEQ || htrans == 2'h3);
    assign acc_rd = accept && !hwrite;
    assign idx    = (haddr[31:12] == 20'h0_0000) ? haddr[11:2] : QBT_IDX_UNMAPPED;

    always_comb begin
        next_st       = st;
        next_st.ready = 1'b1;
        next_st.resp  = 1'b0;
        // write data lands in the data phase, one cycle after its address
        if (st.wr_pend) begin
            if (st.wr_idx == QBT_IDX_QUERY_CTRL) begin
                next_st.query_en = hwdata[0];
            end
            if (st.wr_idx == QBT_IDX_BURST_CFG) begin
                next_st.burst_sel = hwdata[2:0];
            end
        end
        next_st.wr_pend = accept && hwrite;
        next_st.wr_idx  = idx;
        // read data prepared at the address phase so hrdata is a flop
        if (acc_rd) begin
            next_st.rdata = qbt_read_word(idx, st.query_en, st.burst_sel, PART_REGIONS);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st.rdata     <= 32'h0000_0000;
            st.ready     <= 1'b1;
            st.resp      <= 1'b0;
            st.wr_pend   <= 1'b0;
            st.wr_idx    <= 10'h000;
            st.query_en  <= QBT_QUERY_EN_RST;
            st.burst_sel <= QBT_BURST_SEL_RST;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata    = st.rdata;
    assign hreadyout = st.ready;
    assign hresp     = st.resp;

    // a write followed at once by a read of the same word sees the old value
    chk_page_size_value: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_PAGE_CAP && $past(st.query_en)
        |-> hrdata == 32'h0000_0005)
        else $error("page size entry not 05");

    chk_page_present_flag: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_BURST_STAT |-> hrdata[QBT_STAT_PAGE_BIT])
        else $error("page buffer flag wrong");

    chk_field_count_value: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_FIELD_COUNT && $past(st.query_en)
        |-> hrdata == 32'h0000_0004 ##0 st.ready)
        else $error("field count not 04");

    chk_burst_length_decode: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_BURST_STAT && $past(st.burst_sel) != 3'h7
        |-> hrdata[7:0] == (8'h01 << ($past(st.burst_sel) + 3'h1)) && !hrdata[8])
        else $error("burst length decode wrong");

    chk_continuous_burst: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_BURST_STAT && $past(st.burst_sel) == 3'h7
        |-> hrdata[8] && hrdata[7:0] == 8'h00)
        else $error("continuous burst not flagged");

    chk_config_entries: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(st.query_en)
        && $past(idx) >= QBT_IDX_CFG_FIRST && $past(idx) <= QBT_IDX_CFG_FOURTH
        |-> ($past(idx) == QBT_IDX_CFG_FIRST  && hrdata == 32'h0000_0001)
         || ($past(idx) == QBT_IDX_CFG_SECOND && hrdata == 32'h0000_0002)
         || ($past(idx) == QBT_IDX_CFG_THIRD  && hrdata == 32'h0000_0003)
         || ($past(idx) == QBT_IDX_CFG_FOURTH && hrdata == 32'h0000_0007))
        else $error("config entry value wrong");

    chk_partition_count: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_PART_COUNT && $past(st.query_en)
        |-> hrdata == {24'h00_0000, PART_REGIONS})
        else $error("partition count wrong");

    chk_upper_byte_zero: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) >= QBT_IDX_PAGE_CAP && $past(idx) <= QBT_IDX_PART_COUNT
        |-> hrdata[31:8] == 24'h00_0000 ##1 (hrdata == $past(hrdata) || $past(acc_rd)))
        else $error("upper data bits not zero");

    chk_ready_okay: assert property (@(posedge clk) disable iff (rst)
        hreadyout && !hresp)
        else $error("slave stalled or erred");

    // query mode off hides the table but not the control words
    chk_table_blanked: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && !$past(st.query_en)
        && $past(idx) >= QBT_IDX_PAGE_CAP && $past(idx) <= QBT_IDX_PART_COUNT
        |-> hrdata == 32'h0000_0000)
        else $error("table not blanked");

    chk_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_UNMAPPED |-> hrdata == 32'h0000_0000)
        else $error("unmapped word not zero");

    // the host copies a config byte here; only three bits are kept
    chk_burst_cfg_lands: assert property (@(posedge clk) disable iff (rst)
        $past(st.wr_pend) && $past(st.wr_idx) == QBT_IDX_BURST_CFG
        |-> st.burst_sel == $past(hwdata[2:0]))
        else $error("burst config write lost");

    chk_query_en_lands: assert property (@(posedge clk) disable iff (rst)
        $past(st.wr_pend) && $past(st.wr_idx) == QBT_IDX_QUERY_CTRL
        |-> st.query_en == $past(hwdata[0]))
        else $error("query enable write lost");

    chk_burst_cfg_readback: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_BURST_CFG
        |-> hrdata == {29'h0000_0000, $past(st.burst_sel)})
        else $error("burst config readback wrong");

    chk_burst_capable_flag: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_BURST_STAT |-> hrdata[QBT_STAT_BURST_BIT])
        else $error("burst capable flag wrong");

    chk_single_part_flag: assert property (@(posedge clk) disable iff (rst)
        $past(acc_rd) && $past(idx) == QBT_IDX_BURST_STAT
        |-> hrdata[QBT_STAT_SINGLE_BIT] == (PART_REGIONS == 8'h00))
        else $error("single partition flag wrong");

    // read data must stand until the next accepted read
    chk_rdata_holds: assert property (@(posedge clk) disable iff (rst)
        !$past(acc_rd) |-> $stable(hrdata))
        else $error("read data moved without a read");

    chk_no_stray_write: assert property (@(posedge clk) disable iff (rst)
        !$past(accept && hwrite) |-> !st.wr_pend)
        else $error("write pending without a write");

endmodule

`default_nettype wire

// *** qbt_pkg.sv ***
// package for the burst query table: word indexes, table values, field layout
// assumes a 32-bit ahb-lite slave with word-aligned registers at 4 x index
`default_nettype none

package qbt_pkg;

    // table indexes; byte address is four times the index
    localparam logic [9:0] QBT_IDX_PAGE_CAP    = 10'h127;
    localparam logic [9:0] QBT_IDX_FIELD_COUNT = 10'h128;
    localparam logic [9:0] QBT_IDX_CFG_FIRST   = 10'h129;
    localparam logic [9:0] QBT_IDX_CFG_SECOND  = 10'h12a;
    localparam logic [9:0] QBT_IDX_CFG_THIRD   = 10'h12b;
    localparam logic [9:0] QBT_IDX_CFG_FOURTH  = 10'h12c;
    localparam logic [9:0] QBT_IDX_PART_COUNT  = 10'h12d;
    // control and status words beside the table
    localparam logic [9:0] QBT_IDX_QUERY_CTRL  = 10'h140;
    localparam logic [9:0] QBT_IDX_BURST_CFG   = 10'h141;
    localparam logic [9:0] QBT_IDX_BURST_STAT  = 10'h142;
    localparam logic [9:0] QBT_IDX_UNMAPPED    = 10'h3ff;

    // table contents
    localparam logic [7:0] QBT_PAGE_CAP_VAL    = 8'h05;
    localparam logic [7:0] QBT_FIELD_COUNT_VAL = 8'h04;
    localparam logic [7:0] QBT_CFG_FIRST_VAL   = 8'h01;
    localparam logic [7:0] QBT_CFG_SECOND_VAL  = 8'h02;
    localparam logic [7:0] QBT_CFG_THIRD_VAL   = 8'h03;
    localparam logic [7:0] QBT_CFG_FOURTH_VAL  = 8'h07;
    localparam logic [7:0] QBT_PART_COUNT_DEF  = 8'h01;

    // field layout
    localparam logic [2:0] QBT_BURST_CONTINUOUS = 3'h7;
    localparam int         QBT_STAT_CONT_BIT    = 8;
    localparam int         QBT_STAT_PAGE_BIT    = 9;
    localparam int         QBT_STAT_BURST_BIT   = 10;
    localparam int         QBT_STAT_SINGLE_BIT  = 11;

    // values after reset
    localparam logic       QBT_QUERY_EN_RST  = 1'b1;
    localparam logic [2:0] QBT_BURST_SEL_RST = 3'h1;

    localparam logic [1:0] QBT_HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        resp;
        logic        wr_pend;
        logic [9:0]  wr_idx;
        logic        query_en;
        logic [2:0]  burst_sel;
    } qbt_state_type;

    // burst length in words at full width; zero for the continuous code
    function automatic logic [7:0] qbt_burst_words(input logic [2:0] sel);
        logic [7:0] words;
        words = 8'h00;
        if (sel != QBT_BURST_CONTINUOUS) begin
            words = 8'h01 << (sel + 3'h1);
        end
        return words;
    endfunction

    function automatic logic [31:0] qbt_read_word(input logic [9:0] idx,
                                                  input logic       en,
                                                  input logic [2:0] sel,
                                                  input logic [7:0] part);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            QBT_IDX_PAGE_CAP:    w = {24'h00_0000, QBT_PAGE_CAP_VAL};
            QBT_IDX_FIELD_COUNT: w = {24'h00_0000, QBT_FIELD_COUNT_VAL};
            QBT_IDX_CFG_FIRST:   w = {24'h00_0000, QBT_CFG_FIRST_VAL};
            QBT_IDX_CFG_SECOND:  w = {24'h00_0000, QBT_CFG_SECOND_VAL};
            QBT_IDX_CFG_THIRD:   w = {24'h00_0000, QBT_CFG_THIRD_VAL};
            QBT_IDX_CFG_FOURTH:  w = {24'h00_0000, QBT_CFG_FOURTH_VAL};
            QBT_IDX_PART_COUNT:  w = {24'h00_0000, part};
            default:             w = 32'h0000_0000;
        endcase
        if (!en) begin
            w = 32'h0000_0000;
        end
        case (idx)
            QBT_IDX_QUERY_CTRL: w = {31'h0000_0000, en};
            QBT_IDX_BURST_CFG:  w = {29'h0000_0000, sel};
            QBT_IDX_BURST_STAT: begin
                w = {24'h00_0000, qbt_burst_words(sel)};
                w[QBT_STAT_CONT_BIT]   = (sel == QBT_BURST_CONTINUOUS);
                w[QBT_STAT_PAGE_BIT]   = (QBT_PAGE_CAP_VAL != 8'h00);
                w[QBT_STAT_BURST_BIT]  = (QBT_FIELD_COUNT_VAL != 8'h00);
                w[QBT_STAT_SINGLE_BIT] = (part == 8'h00);
            end
            default: ;
        endcase
        return w;
    endfunction

endpackage

`default_nettype wire

// *** qbt_host_model.sv ***
// host model: ahb-lite master reading query space and setting burst length
// assumes one slave whose hreadyout comes back as hready
`default_nettype none

module qbt_host_model
    import qbt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // single word transfer; no latency assumed, only hready ends a phase
    task automatic xfer(input logic w, input logic [9:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, idx, 2'b00};
        htrans <= QBT_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // copies the three burst bits of a config byte as they stand
    task automatic adopt(input logic [9:0] idx);
        logic [31:0] v;
        xfer(1'b0, idx, 32'h0000_0000, v);
        xfer(1'b1, QBT_IDX_BURST_CFG, {29'h0000_0000, v[2:0]}, v);
    endtask
endmodule

`default_nettype wire

// *** qbt_query_table_tb_top.sv ***
// bench for the burst query table: table, status and control words
// assumes the host model as sole master and a 50 MHz clock
`default_nettype none

module qbt_query_table_tb_top
    import qbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] PART = 8'h00;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  tbl [7] = '{8'h05, 8'h04, 8'h01, 8'h02, 8'h03, 8'h07, PART};
    int          n_errors = 0;
    int          checked = 0;
    int          cycles = 0;

    always #10 clk = ~clk;

    qbt_query_table #(.PART_REGIONS(PART)) dut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    qbt_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("errors %0d of %0d compares", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // a hang ends here; the whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            host.xfer(1'b0, QBT_IDX_PAGE_CAP + 10'(i), 32'h0, rd);
            check(rd, {24'h00_0000, tbl[i]});
        end
        // table is read-only, a write leaves it
        host.xfer(1'b1, QBT_IDX_PAGE_CAP, 32'hffff_ffff, rd);
        host.xfer(1'b0, QBT_IDX_PAGE_CAP, 32'h0, rd);
        check(rd, 32'h0000_0005);
        // bits 9 to 11: page buffer, burst capable, single partition
        for (int i = 0; i < 4; i++) begin
            host.adopt(QBT_IDX_CFG_FIRST + 10'(i));
            host.xfer(1'b0, QBT_IDX_BURST_STAT, 32'h0, rd);
            check(rd, {20'h0_0000, 3'b111, tbl[2+i] == 8'h07,
                tbl[2+i] == 8'h07 ? 8'h00 : 8'h01 << (tbl[2+i] + 1)});
        end
        host.xfer(1'b0, QBT_IDX_BURST_CFG, 32'h0, rd);
        check(rd, 32'h0000_0007);
        // query off blanks the table only
        host.xfer(1'b1, QBT_IDX_QUERY_CTRL, 32'h0, rd);
        host.xfer(1'b0, QBT_IDX_CFG_FOURTH, 32'h0, rd);
        check(rd, 32'h0000_0000);
        host.xfer(1'b0, QBT_IDX_UNMAPPED, 32'h0, rd);
        check(rd, 32'h0000_0000);
        check({31'h0, hresp}, 32'h0);
        // second reset brings back query mode and the default burst
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        host.xfer(1'b0, QBT_IDX_BURST_CFG, 32'h0, rd);
        check(rd, 32'h0000_0001);
        host.xfer(1'b0, QBT_IDX_PAGE_CAP, 32'h0, rd);
        check(rd, 32'h0000_0005);
        results();
    end
endmodule

`default_nettype wire
